/* rtl/xps_consts.svh */
`ifndef XPS_CONSTS_SVH
`define XPS_CONSTS_SVH

`define XPS_WORD_W       16
`define XPS_IN_W         5
`define XPS_OUT_W        4
`define XPS_N_OUT        16
`define XPS_BANK_W       8
`define XPS_SYNC_N       2

// command field and word layout
`define XPS_CMD_HI       15
`define XPS_CMD_LO       13
`define XPS_IN_HI        8
`define XPS_IN_LO        4
`define XPS_OUTSEL_HI    3
`define XPS_OUTSEL_LO    0
`define XPS_BANK_HI      9
`define XPS_BANK_LO      8
`define XPS_BCAST_EN_BIT 0
`define XPS_GOE_BIT      0
`define XPS_CLAMP_BIT    1

// reset values
`define XPS_RST_MAP      5'h00
`define XPS_RST_BITS     16'h0000

// link timing
`define XPS_CORE_HZ      25000000
`define XPS_SCLK_MAX_HZ  5000000
`define XPS_HALF_CYC ((`XPS_CORE_HZ + 2*`XPS_SCLK_MAX_HZ - 1) / (2*`XPS_SCLK_MAX_HZ))
`define XPS_STROBE_CYC   `XPS_HALF_CYC

`endif

/* rtl/xps_device.sv */
`timescale 1ns/1ps
`default_nettype none
`include "xps_consts.svh"

module xps_device
  import xps_pkg::*;
(
  // core clock and reset
  input  wire logic                I_CORE_CLK,
  input  wire logic                I_RSTN,
  input  wire logic                I_CE,
  // serial link
  xps_link_if.device               LINK,
  // decoded configuration
  output logic [`XPS_N_OUT-1:0][`XPS_IN_W-1:0] O_ROUTE,
  output logic [`XPS_N_OUT-1:0]    O_DRIVE,
  output logic [`XPS_N_OUT-1:0]    O_GAIN2,
  output logic                     O_BCAST,
  output logic                     O_CLAMP,
  output logic                     O_STANDBY
);

  // ---------------- link domain, clocked by the serial clock
  xps_link_t link;
  xps_link_t next_link;
  logic      sdo_q;

  always_comb begin
    next_link = link;
    // new bit enters at the top, first bit ends up in bit 0
    next_link.shift = {LINK.sdi, link.shift[`XPS_WORD_W-1:1]};
  end

  // shifting never depends on the strobe
  always_ff @(posedge LINK.sclk or negedge I_RSTN) begin
    if (!I_RSTN) begin
      link.shift <= `XPS_RST_BITS;
    end else begin
      link <= next_link;
    end
  end

  // bit taken 15 rising edges ago leaves on the next falling edge
  always_ff @(negedge LINK.sclk or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= link.shift[0];
    end
  end

  // pure delay line, never register contents
  assign LINK.sdo = sdo_q;

  // ---------------- core domain
  xps_dev_t st;
  xps_dev_t nx;

  logic                   strobe_rise;
  logic [`XPS_WORD_W-1:0] word;
  xps_cmd_t               cmd;
  logic [`XPS_IN_W-1:0]   in_sel;
  logic [`XPS_OUT_W-1:0]  out_sel;
  logic [1:0]             bank;
  logic [`XPS_BANK_W-1:0] bank_bits;

  assign strobe_rise = st.strobe_sync[`XPS_SYNC_N-1] & ~st.strobe_prev;
  assign word        = st.word_s2;
  assign cmd         = xps_cmd_t'(word[`XPS_CMD_HI:`XPS_CMD_LO]);
  assign in_sel      = word[`XPS_IN_HI:`XPS_IN_LO];
  assign out_sel     = word[`XPS_OUTSEL_HI:`XPS_OUTSEL_LO];
  assign bank        = word[`XPS_BANK_HI:`XPS_BANK_LO];
  assign bank_bits   = word[`XPS_BANK_W-1:0];

  always_comb begin
    nx = st;
    // strobe is a pin: two flops before the edge detector
    nx.strobe_sync = {st.strobe_sync[`XPS_SYNC_N-2:0], LINK.load_strobe};
    nx.strobe_prev = st.strobe_sync[`XPS_SYNC_N-1];
    // word is static while the host holds the clock still around the
    // strobe; the two stages line it up with the synced strobe
    nx.word_s1 = link.shift;
    nx.word_s2 = st.word_s1;

    if (strobe_rise) begin
      case (cmd)
        XPS_CMD_MAP: begin
          // only this output changes, others may share the input
          nx.map[out_sel] = in_sel;
        end
        XPS_CMD_OEN: begin
          // only banks 0 and 1 hold real outputs
          case (bank)
            2'h0: nx.out_en[7:0] = bank_bits;
            2'h1: nx.out_en[15:8] = bank_bits;
            default: nx.out_en = st.out_en;
          endcase
        end
        XPS_CMD_GAIN: begin
          case (bank)
            2'h0: nx.gain[7:0] = bank_bits;
            2'h1: nx.gain[15:8] = bank_bits;
            default: nx.gain = st.gain;
          endcase
        end
        XPS_CMD_BCAST: begin
          // map itself is left alone so it returns when broadcast ends
          nx.bcast_in = in_sel;
          nx.bcast_on = word[`XPS_BCAST_EN_BIT];
        end
        XPS_CMD_CTRL: begin
          nx.goe     = word[`XPS_GOE_BIT];
          nx.clamp   = word[`XPS_CLAMP_BIT];
          nx.standby = 1'b0;
        end
        default: begin
          nx = nx;
        end
      endcase
    end

    // registered outputs follow the committed configuration
    for (int o = 0; o < `XPS_N_OUT; o++) begin
      nx.route_q[o] = nx.bcast_on ? nx.bcast_in : nx.map[o];
    end
    nx.drive_q = nx.out_en & {`XPS_N_OUT{nx.goe & ~nx.standby}};
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st.strobe_sync <= '0;
      st.strobe_prev <= 1'b0;
      st.word_s1     <= `XPS_RST_BITS;
      st.word_s2     <= `XPS_RST_BITS;
      st.map         <= '0;
      st.out_en      <= `XPS_RST_BITS;
      st.gain        <= `XPS_RST_BITS;
      st.bcast_in    <= `XPS_RST_MAP;
      st.bcast_on    <= 1'b0;
      st.goe         <= 1'b0;
      st.clamp       <= 1'b0;
      st.standby     <= 1'b1;
      st.route_q     <= '0;
      st.drive_q     <= `XPS_RST_BITS;
    end else if (I_CE) begin
      st <= nx;
    end
  end

  assign O_ROUTE   = st.route_q;
  assign O_DRIVE   = st.drive_q;
  assign O_GAIN2   = st.gain;
  assign O_BCAST   = st.bcast_on;
  assign O_CLAMP   = st.clamp;
  assign O_STANDBY = st.standby;

endmodule

`default_nettype wire

/* rtl/xps_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "xps_consts.svh"

module xps_host
  import xps_pkg::*;
(
  // core clock and reset
  input  wire logic                   I_CORE_CLK,
  input  wire logic                   I_RSTN,
  input  wire logic                   I_CE,
  // word request
  input  wire logic [`XPS_WORD_W-1:0] I_WORD,
  input  wire logic                   I_WORD_VALID,
  input  wire logic                   I_WORD_LAST,
  output logic                        O_READY,
  // serial link
  xps_link_if.host                    LINK
);

  localparam logic [7:0] HALF   = 8'(`XPS_HALF_CYC);
  localparam logic [7:0] STROBE = 8'(`XPS_STROBE_CYC);
  localparam logic [4:0] NBITS  = 5'(`XPS_WORD_W);

  xps_host_t st;
  xps_host_t nx;

  always_comb begin
    nx = st;
    case (st.state)
      XPS_H_IDLE: begin
        if (st.ready && I_WORD_VALID) begin
          nx.word  = I_WORD;
          nx.last  = I_WORD_LAST;
          nx.bits  = 5'h00;
          nx.cnt   = 8'h00;
          nx.ready = 1'b0;
          nx.sdi   = I_WORD[0];
          nx.state = XPS_H_LOW;
        end
      end
      XPS_H_LOW: begin
        // clock low for a half period, data already set up
        if (st.cnt == HALF - 8'h01) begin
          nx.cnt   = 8'h00;
          nx.sclk  = 1'b1;
          nx.state = XPS_H_HIGH;
        end else begin
          nx.cnt = st.cnt + 8'h01;
        end
      end
      XPS_H_HIGH: begin
        if (st.cnt == HALF - 8'h01) begin
          nx.cnt  = 8'h00;
          nx.sclk = 1'b0;
          nx.bits = st.bits + 5'h01;
          nx.word = {1'b0, st.word[`XPS_WORD_W-1:1]};
          nx.sdi  = st.word[1];
          if (st.bits == NBITS - 5'h01) begin
            // strobe only after a full word; chained words hold it back
            if (st.last) begin
              nx.strobe = 1'b1;
              nx.state  = XPS_H_LATCH;
            end else begin
              nx.ready = 1'b1;
              nx.state = XPS_H_IDLE;
            end
          end else begin
            nx.state = XPS_H_LOW;
          end
        end else begin
          nx.cnt = st.cnt + 8'h01;
        end
      end
      XPS_H_LATCH: begin
        if (st.cnt == STROBE - 8'h01) begin
          nx.cnt    = 8'h00;
          nx.strobe = 1'b0;
          nx.ready  = 1'b1;
          nx.state  = XPS_H_IDLE;
        end else begin
          nx.cnt = st.cnt + 8'h01;
        end
      end
      default: begin
        nx.state = XPS_H_IDLE;
        nx.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st.state  <= XPS_H_IDLE;
      st.cnt    <= 8'h00;
      st.bits   <= 5'h00;
      st.word   <= `XPS_RST_BITS;
      st.last   <= 1'b0;
      st.sclk   <= 1'b0;
      st.sdi    <= 1'b0;
      st.strobe <= 1'b0;
      st.ready  <= 1'b1;
    end else if (I_CE) begin
      st <= nx;
    end
  end

  assign O_READY          = st.ready;
  assign LINK.sclk        = st.sclk;
  assign LINK.sdi         = st.sdi;
  assign LINK.load_strobe = st.strobe;

endmodule

`default_nettype wire

/* rtl/xps_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface xps_link_if;
  logic sclk;
  logic sdi;
  logic load_strobe;
  logic sdo;

  modport host (
    output sclk,
    output sdi,
    output load_strobe,
    input  sdo
  );

  modport device (
    input  sclk,
    input  sdi,
    input  load_strobe,
    output sdo
  );
endinterface

`default_nettype wire

/* rtl/xps_pkg.sv */
`include "xps_consts.svh"

package xps_pkg;

  typedef enum logic [2:0] {
    XPS_CMD_MAP   = 3'h0,
    XPS_CMD_OEN   = 3'h1,
    XPS_CMD_GAIN  = 3'h2,
    XPS_CMD_BCAST = 3'h3,
    XPS_CMD_CTRL  = 3'h4
  } xps_cmd_t;

  typedef enum logic [1:0] {
    XPS_H_IDLE  = 2'h0,
    XPS_H_LOW   = 2'h1,
    XPS_H_HIGH  = 2'h2,
    XPS_H_LATCH = 2'h3
  } xps_hstate_t;

  typedef logic [`XPS_N_OUT-1:0][`XPS_IN_W-1:0] xps_map_t;

  typedef struct packed {
    logic [`XPS_WORD_W-1:0] shift;
  } xps_link_t;

  typedef struct packed {
    logic [`XPS_SYNC_N-1:0] strobe_sync;
    logic                   strobe_prev;
    logic [`XPS_WORD_W-1:0] word_s1;
    logic [`XPS_WORD_W-1:0] word_s2;
    xps_map_t               map;
    logic [`XPS_N_OUT-1:0]  out_en;
    logic [`XPS_N_OUT-1:0]  gain;
    logic [`XPS_IN_W-1:0]   bcast_in;
    logic                   bcast_on;
    logic                   goe;
    logic                   clamp;
    logic                   standby;
    xps_map_t               route_q;
    logic [`XPS_N_OUT-1:0]  drive_q;
  } xps_dev_t;

  typedef struct packed {
    xps_hstate_t            state;
    logic [7:0]             cnt;
    logic [4:0]             bits;
    logic [`XPS_WORD_W-1:0] word;
    logic                   last;
    logic                   sclk;
    logic                   sdi;
    logic                   strobe;
    logic                   ready;
  } xps_host_t;

endpackage

/* verification/crosspoint_serial_config_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "xps_consts.svh"

module crosspoint_serial_config_tb_top;
  logic        core_clk = 1'b0;
  logic        rstn     = 1'b0;
  logic [15:0] word     = 16'h0000;
  logic        valid    = 1'b0;
  logic        last     = 1'b0;
  logic        ready;
  logic [`XPS_N_OUT-1:0][`XPS_IN_W-1:0] route;
  logic [15:0] drive;
  logic [15:0] gain2;
  logic        bcast;
  logic        clamp;
  logic        standby;
  int          bad_count   = 0;
  int          checks_done = 0;

  xps_link_if link ();
  always #20 core_clk = ~core_clk;

  xps_host i_xps_host (.I_CORE_CLK(core_clk), .I_RSTN(rstn), .I_CE(1'b1),
    .I_WORD(word), .I_WORD_VALID(valid), .I_WORD_LAST(last),
    .O_READY(ready), .LINK(link));
  xps_device i_xps_device (.I_CORE_CLK(core_clk), .I_RSTN(rstn),
    .I_CE(1'b1), .LINK(link), .O_ROUTE(route), .O_DRIVE(drive),
    .O_GAIN2(gain2), .O_BCAST(bcast), .O_CLAMP(clamp), .O_STANDBY(standby));
  xps_link_props i_xps_link_props (.I_CORE_CLK(core_clk), .I_RSTN(rstn),
    .sclk(link.sclk), .sdi(link.sdi), .load_strobe(link.load_strobe),
    .sdo(link.sdo));

  task cmp(input logic [79:0] got, input logic [79:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one word through the host; waits for idle plus the commit latency
  // ready is high on entry, so the word is taken at the first edge;
  // ready is read at the falling edge to stay clear of the launch edge
  task send(input logic [15:0] w, input logic l);
    int n;
    n = 0;
    @(posedge core_clk);
    word  <= w;
    last  <= l;
    valid <= 1'b1;
    @(posedge core_clk);
    valid <= 1'b0;
    @(negedge core_clk);
    while (ready !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 200) begin
      bad_count++;
      $display("MISMATCH t=%0t host never returned to idle", $time);
    end
    repeat (6) @(posedge core_clk);
  endtask

  task t_reset();
    cmp(80'(standby), 80'h1);
    cmp(80'(drive), 80'h0);
    cmp(route, 80'h0);
  endtask

  task t_map();
    send(16'h8003, 1'b1);
    cmp(80'(standby), 80'h0);
    cmp(80'(clamp), 80'h1);
    send(16'h01F5, 1'b1);
    send(16'h01F6, 1'b1);
    cmp(80'(route[5]), 80'h1F);
    cmp(80'(route[6]), 80'h1F);
  endtask

  task t_enable();
    send(16'h20A5, 1'b1);
    send(16'h2103, 1'b1);
    cmp(80'(drive), 80'h03A5);
    send(16'h22FF, 1'b1);
    cmp(80'(drive), 80'h03A5);
    send(16'h8000, 1'b1);
    cmp(80'(drive), 80'h0);
    cmp(80'(clamp), 80'h0);
    send(16'h8001, 1'b1);
    cmp(80'(drive), 80'h03A5);
  endtask

  task t_gain();
    send(16'h4181, 1'b1);
    cmp(80'(gain2), 80'h8100);
    send(16'h4001, 1'b1);
    cmp(80'(gain2), 80'h8101);
  endtask

  task t_bcast();
    send(16'h6071, 1'b1);
    cmp(80'(bcast), 80'h1);
    cmp(route, {16{5'h07}});
    send(16'h6070, 1'b1);
    cmp(80'(bcast), 80'h0);
    cmp(80'(route[5]), 80'h1F);
  endtask

  // undefined codes must not disturb anything set so far
  task t_unknown();
    send(16'hFFFF, 1'b1);
    send(16'hA0FF, 1'b1);
    cmp(80'(drive), 80'h03A5);
    cmp(80'(gain2), 80'h8101);
    cmp(80'(route[5]), 80'h1F);
    cmp(80'(standby), 80'h0);
  endtask

  // first word passes on down the chain; only the last one lands here
  task t_chain();
    send(16'h0012, 1'b0);
    send(16'h0142, 1'b1);
    cmp(80'(route[2]), 80'h14);
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_map();
    t_enable();
    t_gain();
    t_bcast();
    t_unknown();
    t_chain();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    print_verdict();
  end
endmodule

`default_nettype wire

/* verification/xps_link_props.sv */
`timescale 1ns/1ps
`default_nettype none

module xps_link_props (
  // core clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  // serial link
  input wire logic sclk,
  input wire logic sdi,
  input wire logic load_strobe,
  input wire logic sdo
);
  logic [15:0] hist;
  logic [5:0]  nbits;
  logic        sclk_d;

  // bits seen on sdi, link domain
  always_ff @(posedge sclk or negedge I_RSTN) begin
    if (!I_RSTN) begin
      hist <= 16'h0000;
    end else begin
      hist <= {hist[14:0], sdi};
    end
  end

  // rising sclk edges since the last strobe
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sclk_d <= 1'b0;
      nbits  <= 6'h00;
    end else begin
      sclk_d <= sclk;
      if (load_strobe) begin
        nbits <= 6'h00;
      end else if (sclk && !sclk_d) begin
        nbits <= nbits + 6'h01;
      end
    end
  end

  sequence s_hi3;
    sclk [*3] ##1 !sclk;
  endsequence
  sequence s_strobe;
    load_strobe [*3] ##1 !load_strobe;
  endsequence

  property p_sclk_high;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN) $rose(sclk) |-> s_hi3;
  endproperty
  property p_sclk_low;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN) $fell(sclk) |-> !sclk [*3];
  endproperty
  property p_sdi_setup;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN) $changed(sdi) |-> !sclk;
  endproperty
  property p_strobe_len;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN) $rose(load_strobe) |-> s_strobe;
  endproperty
  property p_strobe_quiet;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      $rose(load_strobe) |-> !sclk [*6];
  endproperty
  property p_strobe_whole;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      $rose(load_strobe) |-> (nbits != 6'h00) && (nbits[3:0] == 4'h0);
  endproperty
  property p_sdo_edge;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN) $changed(sdo) |-> $fell(sclk);
  endproperty
  property p_sdo_delay;
    @(posedge sclk) disable iff (!I_RSTN) sdo == hist[15];
  endproperty

  a_sclk_high: assert property (p_sclk_high)
    else $error("sclk high time wrong");
  a_sclk_low: assert property (p_sclk_low)
    else $error("sclk low time wrong");
  a_sdi_setup: assert property (p_sdi_setup)
    else $error("sdi changed while sclk high");
  a_strobe_len: assert property (p_strobe_len)
    else $error("strobe length wrong");
  a_strobe_quiet: assert property (p_strobe_quiet)
    else $error("sclk moved around strobe");
  a_strobe_whole: assert property (p_strobe_whole)
    else $error("strobe after partial word");
  a_sdo_edge: assert property (p_sdo_edge)
    else $error("sdo changed off falling sclk");
  a_sdo_delay: assert property (p_sdo_delay)
    else $error("sdo not sdi delayed");
endmodule

`default_nettype wire
